// [include/mcsr_map.vh]
// Address map, field positions and reset values of the core special registers.
// Included by the core register module only; holds definitions only.
`ifndef MCSR_MAP_VH
`define MCSR_MAP_VH

// Register addresses, full 8-bit form {bank_select_bit, 7-bit operand}
`define MCSR_A_INDIR 8'h00
`define MCSR_A_TIMER 8'h01
`define MCSR_A_PCL 8'h02
`define MCSR_A_FLAGS 8'h03
`define MCSR_A_PTR 8'h04
`define MCSR_A_PCHB 8'h0a
`define MCSR_A_IGATE 8'h0b
`define MCSR_A_TIMER_PRESCALE_CONTROL 8'h81
`define MCSR_BANK_BIT 7

// General-purpose register area
`define MCSR_GPR_BASE 8'h20
`define MCSR_GPR_LAST 8'h5f
`define MCSR_GPR_AW 6

// Decode results
`define MCSR_S_NONE 4'h0
`define MCSR_S_INDIR 4'h1
`define MCSR_S_TIMER 4'h2
`define MCSR_S_PCL 4'h3
`define MCSR_S_FLAGS 4'h4
`define MCSR_S_PTR 4'h5
`define MCSR_S_PCHB 4'h6
`define MCSR_S_IGATE 4'h7
`define MCSR_S_TIMER_PRESCALE_CONTROL 4'h8
`define MCSR_S_GPR 4'h9

// core_flags fields
`define MCSR_F_BS 5
`define MCSR_F_ZF 2
`define MCSR_F_HC 1
`define MCSR_F_CF 0

// interrupt_gate fields
`define MCSR_I_GIE 7
`define MCSR_I_TEN 5
`define MCSR_I_TOF 2

// timer_prescale_control fields
`define MCSR_P_DIS 3
`define MCSR_P_RATE_HI 2

// Reset values, timer maximum and interrupt vector
`define MCSR_R_TIMER 8'h00
`define MCSR_R_PC 11'h000
`define MCSR_R_PCHB 3'h0
`define MCSR_R_PTR 8'h00
`define MCSR_R_TIMER_PRESCALE_CONTROL 4'hf
`define MCSR_R_BYTE 8'h00
`define MCSR_TIMER_MAX 8'hff
`define MCSR_IRQ_VECTOR 11'h008

`endif

// [design/mcsr_ret_stack.v]
// Hardware return stack: circular, pointer hidden from software.
// Assumes push and pop are never asserted together.
`timescale 1ns/10ps
module mcsr_ret_stack #(
	parameter DEPTH = 4,
	parameter PTR_W = 2,
	parameter WIDTH = 11
)
(
	input wire sys_clk,
	input wire rst,
	input wire ce,
	input wire push,
	input wire pop,
	input wire [WIDTH-1:0] push_data,
	output wire [WIDTH-1:0] top_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [PTR_W-1:0] ptr_q;
	wire [PTR_W-1:0] ptr_dec;
	integer i;

	assign ptr_dec = ptr_q - {{(PTR_W-1){1'b0}}, 1'b1};
	assign top_data = mem[ptr_dec];

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ptr_q <= {PTR_W{1'b0}};
			for (i = 0; i < DEPTH; i = i + 1)
				mem[i] <= {WIDTH{1'b0}};
		end
		else if (ce)
		begin
			if (push)
			begin
				// Wraps onto the oldest entry when full
				mem[ptr_q] <= push_data;
				ptr_q <= ptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
			end
			else if (pop)
				ptr_q <= ptr_dec;
		end
	end
endmodule

// [design/mcsr_core_regs.v]
// Special-function registers of a small 8-bit core: indirect window, timer,
// program counter, return stack, flags and interrupt gate, plus the GPR area.
// Assumes one instruction-side access per cycle from core logic on sys_clk.
`timescale 1ns/10ps
`include "mcsr_map.vh"
module mcsr_core_regs #(
	parameter GPR_DEPTH = 64,
	parameter STACK_DEPTH = 4
)
(
	input wire sys_clk,
	input wire rst,
	input wire ce,
	input wire [6:0] reg_addr,
	input wire reg_rd,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_q,
	input wire instr_cycle,
	input wire pc_inc,
	input wire jump,
	input wire call,
	input wire [7:0] target_low,
	input wire return_with_literal,
	input wire return_from_interrupt,
	input wire return_from_call,
	input wire irq_take,
	input wire alu_flags_en,
	input wire alu_arith,
	input wire alu_sub,
	input wire [7:0] alu_a,
	input wire [7:0] alu_b,
	input wire [7:0] alu_result,
	output reg [10:0] pc_q,
	output reg irq_q,
	output reg bank_select_bit_q,
	output reg zero_flag_q,
	output reg half_carry_flag_q,
	output reg carry_flag_q
);
	// Maps a full address to a physical register; both banks alias except timer/prescaler (01/81) and the GPR area (bank 0 only)
	function [3:0] mcsr_decode;
		input [7:0] a;
		begin
			mcsr_decode = `MCSR_S_NONE;
			if (a == `MCSR_A_TIMER_PRESCALE_CONTROL)
				mcsr_decode = `MCSR_S_TIMER_PRESCALE_CONTROL;
			else if (a == `MCSR_A_TIMER)
				mcsr_decode = `MCSR_S_TIMER;
			else if (a >= `MCSR_GPR_BASE && a <= `MCSR_GPR_LAST)
				mcsr_decode = `MCSR_S_GPR;
			else
			begin
				case ({1'b0, a[6:0]})
					`MCSR_A_INDIR: mcsr_decode = `MCSR_S_INDIR;
					`MCSR_A_PCL: mcsr_decode = `MCSR_S_PCL;
					`MCSR_A_FLAGS: mcsr_decode = `MCSR_S_FLAGS;
					`MCSR_A_PTR: mcsr_decode = `MCSR_S_PTR;
					`MCSR_A_PCHB: mcsr_decode = `MCSR_S_PCHB;
					`MCSR_A_IGATE: mcsr_decode = `MCSR_S_IGATE;
					default: mcsr_decode = `MCSR_S_NONE;
				endcase
			end
		end
	endfunction

	reg [7:0] gpr [0:GPR_DEPTH-1];
	reg [7:0] timer_q;
	reg [7:0] timer_d;
	reg [7:0] presc_q;
	reg [7:0] presc_d;
	reg [7:0] ptr_q;
	reg [2:0] pchb_q;
	reg gie_q;
	reg ten_q;
	reg tof_q;
	reg tof_d;
	reg [3:0] timer_prescale_control_q;
	reg [10:0] pc_d;
	reg [7:0] rdata_d;
	reg [3:0] sel;
	reg [7:0] eff_addr;
	reg [7:0] flags_rd;
	reg [7:0] gate_rd;
	reg zf_d;
	reg hc_d;
	reg cf_d;
	reg bs_d;

	wire [7:0] direct_addr;
	wire [3:0] direct_sel;
	wire [`MCSR_GPR_AW-1:0] gpr_idx;
	wire [7:0] gpr_off;
	wire [7:0] presc_mask;
	wire presc_hit;
	wire tick;
	wire overflow;
	wire any_return;
	wire push;
	wire [10:0] stack_top;
	wire [7:0] b_eff;
	wire [4:0] nib_sum;
	wire [8:0] full_sum;
	wire wr_sel;

	assign direct_addr = {bank_select_bit_q, reg_addr};
	assign direct_sel = mcsr_decode(direct_addr);
	assign gpr_off = eff_addr - `MCSR_GPR_BASE;
	assign gpr_idx = gpr_off[`MCSR_GPR_AW-1:0];
	assign wr_sel = reg_wr;

	// Prescaler terminal count 2^(rate+1)-1
	assign presc_mask = 8'hff >> (3'd7 - timer_prescale_control_q[`MCSR_P_RATE_HI:0]);
	assign presc_hit = (presc_q & presc_mask) == presc_mask;
	assign tick = instr_cycle & (timer_prescale_control_q[`MCSR_P_DIS] | presc_hit);
	assign overflow = tick & (timer_q == `MCSR_TIMER_MAX);

	assign any_return = return_with_literal | return_from_interrupt | return_from_call;
	assign push = irq_take | call;

	assign b_eff = alu_sub ? ~alu_b : alu_b;
	assign nib_sum = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_sub};
	assign full_sum = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_sub};

	mcsr_ret_stack #(
		.DEPTH(STACK_DEPTH),
		.PTR_W($clog2(STACK_DEPTH)),
		.WIDTH(11)
	) u_stack (
		.sys_clk(sys_clk),
		.rst(rst),
		.ce(ce),
		.push(push),
		.pop(any_return & ~push),
		.push_data(pc_q),
		.top_data(stack_top)
	);

	// Address resolution, indirect through the pointer
	always @*
	begin
		eff_addr = direct_addr;
		sel = direct_sel;
		if (direct_sel == `MCSR_S_INDIR)
		begin
			eff_addr = ptr_q;
			sel = (mcsr_decode(ptr_q) == `MCSR_S_GPR) ? `MCSR_S_GPR : `MCSR_S_NONE;
		end
	end

	// Read data assembly
	always @*
	begin
		flags_rd = `MCSR_R_BYTE;
		flags_rd[`MCSR_F_BS] = bank_select_bit_q;
		flags_rd[`MCSR_F_ZF] = zero_flag_q;
		flags_rd[`MCSR_F_HC] = half_carry_flag_q;
		flags_rd[`MCSR_F_CF] = carry_flag_q;
		gate_rd = `MCSR_R_BYTE;
		gate_rd[`MCSR_I_GIE] = gie_q;
		gate_rd[`MCSR_I_TEN] = ten_q;
		gate_rd[`MCSR_I_TOF] = tof_q;
		case (sel)
			`MCSR_S_TIMER: rdata_d = timer_q;
			`MCSR_S_PCL: rdata_d = pc_q[7:0];
			`MCSR_S_FLAGS: rdata_d = flags_rd;
			`MCSR_S_PTR: rdata_d = ptr_q;
			`MCSR_S_PCHB: rdata_d = {5'h00, pchb_q};
			`MCSR_S_IGATE: rdata_d = gate_rd;
			`MCSR_S_TIMER_PRESCALE_CONTROL: rdata_d = {4'h0, timer_prescale_control_q};
			`MCSR_S_GPR: rdata_d = gpr[gpr_idx];
			default: rdata_d = `MCSR_R_BYTE;
		endcase
	end

	// Timer and prescaler next state
	always @*
	begin
		presc_d = presc_q;
		timer_d = timer_q;
		if (instr_cycle)
			presc_d = presc_hit ? `MCSR_R_BYTE : presc_q + 8'h01;
		if (tick)
			timer_d = timer_q + 8'h01;
		if (wr_sel && sel == `MCSR_S_TIMER)
		begin
			timer_d = reg_wdata;
			presc_d = `MCSR_R_BYTE;
		end
		tof_d = tof_q;
		if (wr_sel && sel == `MCSR_S_IGATE)
			tof_d = reg_wdata[`MCSR_I_TOF];
		if (overflow)
			tof_d = 1'b1;
	end

	// Program counter next state
	always @*
	begin
		pc_d = pc_q;
		if (irq_take)
			pc_d = `MCSR_IRQ_VECTOR;
		else if (any_return)
			pc_d = stack_top;
		else if (wr_sel && sel == `MCSR_S_PCL)
			pc_d = {pchb_q, reg_wdata};
		else if (jump || call)
			pc_d = {pchb_q, target_low};
		else if (pc_inc)
			pc_d = pc_q + 11'h001;
	end

	// Flag next state; ALU update wins over a write to the flag register
	always @*
	begin
		bs_d = bank_select_bit_q;
		zf_d = zero_flag_q;
		hc_d = half_carry_flag_q;
		cf_d = carry_flag_q;
		if (wr_sel && sel == `MCSR_S_FLAGS)
		begin
			bs_d = reg_wdata[`MCSR_F_BS];
			zf_d = reg_wdata[`MCSR_F_ZF];
			hc_d = reg_wdata[`MCSR_F_HC];
			cf_d = reg_wdata[`MCSR_F_CF];
		end
		if (alu_flags_en)
		begin
			zf_d = (alu_result == `MCSR_R_BYTE);
			if (alu_arith)
			begin
				hc_d = nib_sum[4];
				cf_d = full_sum[8];
			end
		end
	end

	always @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata_q <= `MCSR_R_BYTE;
			timer_q <= `MCSR_R_TIMER;
			presc_q <= `MCSR_R_BYTE;
			ptr_q <= `MCSR_R_PTR;
			pchb_q <= `MCSR_R_PCHB;
			gie_q <= 1'b0;
			ten_q <= 1'b0;
			tof_q <= 1'b0;
			timer_prescale_control_q <= `MCSR_R_TIMER_PRESCALE_CONTROL;
			pc_q <= `MCSR_R_PC;
			irq_q <= 1'b0;
			bank_select_bit_q <= 1'b0;
			zero_flag_q <= 1'b0;
			half_carry_flag_q <= 1'b0;
			carry_flag_q <= 1'b0;
		end
		else if (ce)
		begin
			if (reg_rd)
				reg_rdata_q <= rdata_d;
			timer_q <= timer_d;
			presc_q <= presc_d;
			tof_q <= tof_d;
			pc_q <= pc_d;
			irq_q <= tof_d & ten_q & gie_q;
			bank_select_bit_q <= bs_d;
			zero_flag_q <= zf_d;
			half_carry_flag_q <= hc_d;
			carry_flag_q <= cf_d;
			if (wr_sel)
			begin
				case (sel)
					`MCSR_S_PTR: ptr_q <= reg_wdata;
					`MCSR_S_PCHB: pchb_q <= reg_wdata[2:0];
					`MCSR_S_TIMER_PRESCALE_CONTROL: timer_prescale_control_q <= reg_wdata[3:0];
					`MCSR_S_IGATE:
					begin
						gie_q <= reg_wdata[`MCSR_I_GIE];
						ten_q <= reg_wdata[`MCSR_I_TEN];
					end
					default: ;
				endcase
			end
		end
	end

	// GPR storage, no reset
	always @(posedge sys_clk)
	begin
		if (ce && wr_sel && sel == `MCSR_S_GPR)
			gpr[gpr_idx] <= reg_wdata;
	end
endmodule

// [bench/mcsr_props_properties.sv]
// Port checker for the core special registers.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
module mcsr_props (
	input wire sys_clk,
	input wire rst,
	input wire ce,
	input wire [6:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire pc_inc,
	input wire jump,
	input wire call,
	input wire [7:0] target_low,
	input wire return_with_literal,
	input wire return_from_interrupt,
	input wire return_from_call,
	input wire irq_take,
	input wire alu_flags_en,
	input wire alu_arith,
	input wire alu_sub,
	input wire [7:0] alu_a,
	input wire [7:0] alu_b,
	input wire [7:0] alu_result,
	input wire [10:0] pc_q,
	input wire zero_flag_q,
	input wire half_carry_flag_q,
	input wire carry_flag_q
);
	wire go = ce & ~irq_take;
	wire lo = go & ~return_with_literal & ~return_from_interrupt & ~return_from_call;
	wire pc_low_byte = reg_wr & (reg_addr == 7'h02);
	wire add = ce & alu_flags_en & alu_arith & ~alu_sub;
	wire [4:0] hs = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
	wire [8:0] fs = {1'b0, alu_a} + {1'b0, alu_b};
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	a_irq_vector: assert property (ce && irq_take |=> pc_q == 11'h008) else $error("no vector");
	a_pcl_load: assert property (lo && pc_low_byte |=> pc_q[7:0] == $past(reg_wdata)) else $error("pc low");
	a_branch_low: assert property (lo && !pc_low_byte && (jump || call) |=> pc_q[7:0] == $past(target_low))
		else $error("branch");
	a_pc_step: assert property (lo && !reg_wr && !jump && !call && pc_inc |=> pc_q == $past(pc_q) + 11'h001)
		else $error("pc step");
	a_call_return: assert property (lo && call && !reg_wr ##1 go && return_from_call && !call
		|=> pc_q == $past(pc_q, 2)) else $error("return");
	a_zero_flag: assert property (ce && alu_flags_en |=> zero_flag_q == ($past(alu_result) == 8'h00))
		else $error("zero");
	a_half_carry: assert property (add |=> half_carry_flag_q == $past(hs[4])) else $error("half");
	a_carry_out: assert property (add |=> carry_flag_q == $past(fs[8])) else $error("carry");
endmodule
bind mcsr_core_regs mcsr_props i_props (.sys_clk, .rst, .ce, .reg_addr, .reg_wr, .reg_wdata, .pc_inc, .jump,
	.call, .target_low, .return_with_literal, .return_from_interrupt, .return_from_call, .irq_take,
	.alu_flags_en, .alu_arith, .alu_sub, .alu_a, .alu_b, .alu_result, .pc_q, .zero_flag_q,
	.half_carry_flag_q, .carry_flag_q);

// [bench/testbench.sv]
// Directed bench for the core special registers.
// Inputs change 1 ns after each rising edge.
`timescale 1ns/10ps
module testbench;
	reg sys_clk, rst, ce, reg_rd, reg_wr, instr_cycle, pc_inc, jump, call, irq_take;
	reg return_with_literal, return_from_interrupt, return_from_call, alu_flags_en, alu_arith, alu_sub;
	reg [6:0] reg_addr;
	reg [7:0] reg_wdata, target_low, alu_a, alu_b, alu_result;
	wire [7:0] reg_rdata_q;
	wire [10:0] pc_q;
	wire irq_q, bank_select_bit_q, zero_flag_q, half_carry_flag_q, carry_flag_q;
	integer miscompares, num_checks, cycles, k;
	mcsr_core_regs i_dut (.sys_clk, .rst, .ce, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_q,
		.instr_cycle, .pc_inc, .jump, .call, .target_low, .return_with_literal, .return_from_interrupt,
		.return_from_call, .irq_take, .alu_flags_en, .alu_arith, .alu_sub, .alu_a, .alu_b, .alu_result,
		.pc_q, .irq_q, .bank_select_bit_q, .zero_flag_q, .half_carry_flag_q, .carry_flag_q);
	always #2 sys_clk = ~sys_clk;
	task print_verdict;
	begin
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	always @(posedge sys_clk)
	begin
		cycles = cycles + 1;
		if (cycles == 8000)
		begin
			miscompares = miscompares + 1;
			print_verdict;
		end
	end
	task chk(input string n, input [10:0] s, input [10:0] e);
	begin
		num_checks = num_checks + 1;
		if (s !== e)
		begin
			miscompares = miscompares + 1;
			$display("unexpected %0s expected %h seen %h", n, e, s);
		end
	end
	endtask
	task step;
	begin
		@(posedge sys_clk);
		#1;
	end
	endtask
	task wr(input [6:0] a, input [7:0] d);
	begin
		{reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		step;
		reg_wr = 1'b0;
		step;
	end
	endtask
	task rd(input [6:0] a, input [7:0] e);
	begin
		{reg_addr, reg_rd} = {a, 1'b1};
		step;
		reg_rd = 1'b0;
		chk("read data", reg_rdata_q, e);
		step;
	end
	endtask
	task tick(input integer n);
	begin
		repeat (n)
		begin
			instr_cycle = 1'b1;
			step;
			instr_cycle = 1'b0;
			step;
		end
	end
	endtask
	task t_timer;
	begin
		rd(7'h01, 8'h00);
		wr(7'h01, 8'hfe);
		tick(1);
		rd(7'h01, 8'hff);
		tick(1);
		rd(7'h0b, 8'h04);
		wr(7'h0b, 8'h84);
		chk("irq", irq_q, 11'h000);
		wr(7'h0b, 8'ha4);
		chk("irq", irq_q, 11'h001);
		rd(7'h0b, 8'ha4);
		wr(7'h0b, 8'ha0);
		chk("irq", irq_q, 11'h000);
	end
	endtask
	task t_prescale;
	begin
		wr(7'h03, 8'h20);
		chk("bank", bank_select_bit_q, 11'h001);
		rd(7'h01, 8'h0f);
		for (k = 0; k < 8; k = k + 1)
		begin
			wr(7'h03, 8'h20);
			wr(7'h01, {5'h00, k[2:0]});
			wr(7'h03, 8'h00);
			wr(7'h01, 8'h00);
			tick((2 << k) - 1);
			rd(7'h01, 8'h00);
			tick(1);
			rd(7'h01, 8'h01);
		end
	end
	endtask
	task t_pc;
	begin
		wr(7'h0a, 8'h05);
		wr(7'h02, 8'h34);
		chk("pc", pc_q, 11'h534);
		rd(7'h02, 8'h34);
		target_low = 8'h12;
		wr(7'h0a, 8'h03);
		chk("pc", pc_q, 11'h534);
		jump = 1'b1;
		step;
		jump = 1'b0;
		pc_inc = 1'b1;
		chk("pc", pc_q, 11'h312);
		step;
		pc_inc = 1'b0;
		chk("pc", pc_q, 11'h313);
	end
	endtask
	task t_stack;
	begin
		target_low = 8'h40;
		for (k = 0; k < 3; k = k + 1)
		begin
			call = 1'b1;
			step;
			call = 1'b0;
			{return_with_literal, return_from_interrupt, return_from_call} = 3'h4 >> k;
			chk("pc", pc_q, 11'h340);
			step;
			{return_with_literal, return_from_interrupt, return_from_call} = 3'h0;
			chk("pc", pc_q, 11'h313);
			step;
		end
		irq_take = 1'b1;
		step;
		irq_take = 1'b0;
		return_from_interrupt = 1'b1;
		chk("pc", pc_q, 11'h008);
		step;
		return_from_interrupt = 1'b0;
		chk("pc", pc_q, 11'h313);
		rd(7'h0a, 8'h03);
	end
	endtask
	task t_indirect;
	begin
		wr(7'h04, 8'h25);
		wr(7'h00, 8'h5a);
		rd(7'h25, 8'h5a);
		wr(7'h03, 8'h20);
		rd(7'h00, 8'h5a);
		rd(7'h04, 8'h25);
		wr(7'h03, 8'h00);
		wr(7'h04, 8'h0b);
		rd(7'h00, 8'h00);
	end
	endtask
	task alu(input [7:0] a, b, r, input ar, sb, z, h, c);
	begin
		{alu_a, alu_b, alu_result, alu_arith, alu_sub, alu_flags_en} = {a, b, r, ar, sb, 1'b1};
		step;
		alu_flags_en = 1'b0;
		chk("zero", zero_flag_q, z);
		chk("half carry", half_carry_flag_q, h);
		chk("carry", carry_flag_q, c);
		step;
	end
	endtask
	task t_alu;
	begin
		alu(8'hff, 8'h01, 8'h00, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
		alu(8'h10, 8'h01, 8'h0f, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		alu(8'h00, 8'h01, 8'hff, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
		alu(8'h0f, 8'h0f, 8'h1e, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		alu(8'h5a, 8'ha5, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
	end
	endtask
	task t_deep;
	begin
		call = 1'b1;
		for (k = 1; k < 6; k = k + 1)
		begin
			target_low = k[7:0];
			step;
			chk("pc", pc_q, {3'h3, k[7:0]});
		end
		call = 1'b0;
		return_from_call = 1'b1;
		for (k = 4; k > 0; k = k - 1)
		begin
			step;
			chk("pc", pc_q, {3'h3, k[7:0]});
		end
		step;
		return_from_call = 1'b0;
		chk("pc", pc_q, 11'h304);
		ce = 1'b0;
		pc_inc = 1'b1;
		step;
		step;
		chk("pc", pc_q, 11'h304);
		ce = 1'b1;
		step;
		pc_inc = 1'b0;
		chk("pc", pc_q, 11'h305);
		rst = 1'b1;
		step;
		rst = 1'b0;
		chk("pc", pc_q, 11'h000);
		rd(7'h01, 8'h00);
		wr(7'h03, 8'h20);
		rd(7'h01, 8'h0f);
		wr(7'h03, 8'h00);
	end
	endtask
	initial
	begin
		{sys_clk, reg_rd, reg_wr, instr_cycle, pc_inc, jump, call, irq_take} = 8'h00;
		{return_with_literal, return_from_interrupt, return_from_call, alu_flags_en, alu_arith, alu_sub} = 6'h00;
		{reg_addr, reg_wdata, target_low, alu_a, alu_b, alu_result} = 47'h0;
		{rst, ce} = 2'h3;
		{miscompares, num_checks, cycles} = 96'h0;
		repeat (4) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		chk("pc", pc_q, 11'h000);
		t_timer;
		t_prescale;
		t_pc;
		t_stack;
		t_indirect;
		t_alu;
		t_deep;
		print_verdict;
	end
endmodule
